// [design/indicator_zero_and_limit_compare.v]
// Indicator post-processing: auto smoothing, motion detect,
// zero tracking, digital zero and four-limit judgment.
// Assumes samples arrive as one-cycle strobes on mclk and the
// control terminals are asynchronous active-low pins.
//
// How it works
// - stable and enabled selects 1024-sample average
// - smoothing suspended during graph or hold
// - smoothed value feeds indicator, judgments, analog
// - stable when 100 ms change stays below width
// - tracking rezeroes small drift each interval
// - tracking needs calibration lock and zero enable
// - zero time and width disable tracking
// - zero offset subtracted from measured value
// - zero request ignored when zero disabled
// - input over capture limit flags error only
// - no zero capture without calibration lock
// - clear command discards digital zero
// - control inputs are active low
// - check mode forces at most one output (none for select 5-7), freezes indicator
// - strain mode shows two times input
// - analog path selects indicator or raw input
// - limits accepted only when strictly ordered
// - outer judgments off when outer disabled
// - outer limits locked while outer disabled
// - pattern places pass among four limits
// - comparison mode gates judgments six ways
// - standard output compares against own limit
// - area output bounded by neighbouring limit
// - digital zero cleared at reset
`timescale 1ns/1ps
`include "indicator_zero_and_limit_compare_regs.vh"

module indicator_zero_and_limit_compare #(
	parameter MOTION_REF_CYCLES = `MOTION_REF_CYCLES
) (
	input wire mclk, // 20 MHz clock
	input wire srst, // sync reset, high
	input wire hsel, // AHB select
	input wire [31:0] haddr, // AHB address
	input wire [1:0] htrans, // AHB transfer type
	input wire hwrite, // AHB write
	input wire [2:0] hsize, // AHB size
	input wire [31:0] hwdata, // AHB write data
	input wire hready, // AHB bus ready
	output wire hreadyout, // AHB slave ready
	output reg [31:0] hrdata, // AHB read data
	output wire hresp, // AHB response, OKAY
	input wire sample_valid, // new sample strobe
	input wire [23:0] sample_value, // signed sensor value
	input wire graph_active, // graph view shown
	input wire zero_req_n, // zero request pin
	input wire hold_n, // hold pin
	input wire judge_n, // judge enable pin
	input wire clear_n, // clear pin
	input wire select_input_a_n, // select pin a
	input wire select_input_b_n, // select pin b
	output reg [23:0] indicator_value, // signed indicator
	output reg [23:0] analog_value, // to analog converter
	output reg stable, // motion detect result
	output reg upper_outer_judgment, // upper outer output
	output reg upper_inner_judgment, // upper inner output
	output reg pass_judgment, // pass output
	output reg lower_inner_judgment, // lower inner output
	output reg lower_outer_judgment // lower outer output
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function [24:0] mag;
		input [24:0] v;
		begin
			mag = v[24] ? (~v + 25'h0000001) : v;
		end
	endfunction

	function [24:0] diff;
		input [23:0] a;
		input [23:0] b;
		begin
			diff = {a[23], a} - {b[23], b};
		end
	endfunction

	// Signed a < b
	function lt;
		input [23:0] a;
		input [23:0] b;
		begin
			lt = $signed(a) < $signed(b);
		end
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	reg [5:0] pin_s1;
	reg [5:0] pin_s2;
	reg [5:0] pin_s3;
	reg [5:0] pin_on;
	wire [5:0] pin_raw;
	assign pin_raw = {select_input_b_n, select_input_a_n, clear_n,
		judge_n, hold_n, zero_req_n};

	always @(posedge mclk) begin
		if (srst) begin
			pin_s1 <= 6'h3F;
			pin_s2 <= 6'h3F;
			pin_s3 <= 6'h3F;
			pin_on <= 6'h00;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			// Low level counts as on once stages agree
			pin_on <= (~(pin_s2 ^ pin_s3) & ~pin_s2) |
				((pin_s2 ^ pin_s3) & pin_on);
		end
	end

	wire zero_pin_on;
	wire hold_on;
	wire judge_on;
	reg zero_pin_d;
	assign zero_pin_on = pin_on[0];
	assign hold_on = pin_on[1];
	assign judge_on = pin_on[2];

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	reg [31:0] control;
	reg [15:0] motion_time;
	reg [23:0] motion_width;
	reg [15:0] track_time;
	reg [23:0] track_width;
	reg [23:0] zero_offset;
	reg [23:0] zero_limit;
	reg [23:0] near_zero;
	reg [23:0] stage_uo;
	reg [23:0] stage_ui;
	reg [23:0] stage_li;
	reg [23:0] stage_lo;
	reg [23:0] lim_uo;
	reg [23:0] lim_ui;
	reg [23:0] lim_li;
	reg [23:0] lim_lo;
	reg [23:0] zero_adjust;
	reg limit_err;
	reg zero_err;

	wire auto_en = control[`CTL_AUTO_FILTER];
	wire dz_en = control[`CTL_DZ_ENABLE];
	wire cal_lock = control[`CTL_CAL_LOCK];
	wire outer_en = control[`CTL_OUTER_EN];
	wire area_mode = control[`CTL_AREA_MODE];
	wire data_raw = control[`CTL_DATA_RAW];
	wire strain_mode = control[`CTL_STRAIN];
	wire check_mode = control[`CTL_CHECK];
	wire [2:0] check_sel = control[`CTL_CHECK_SEL_LO +: 3];
	wire [2:0] pattern = control[`CTL_PATTERN_LO +: 3];
	wire [2:0] comp_mode = control[`CTL_COMP_MODE_LO +: 3];
	wire judge_sig = control[`CTL_JUDGE_SIG];

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	// Reads take one wait state so hrdata comes from a flop
	reg [7:0] dp_addr;
	reg dp_write;
	reg rd_pend;
	wire take;
	assign take = hsel & htrans[1] & hready;
	assign hreadyout = ~rd_pend;
	assign hresp = 1'b0;

	always @(posedge mclk) begin
		if (srst) begin
			dp_addr <= 8'h00;
			dp_write <= 1'b0;
			rd_pend <= 1'b0;
		end else begin
			if (take) begin
				dp_addr <= haddr[7:0];
			end
			dp_write <= take & hwrite;
			rd_pend <= take & ~hwrite;
		end
	end

	wire wr_ctl = dp_write && dp_addr == `OFS_CONTROL;
	wire wr_cmd = dp_write && dp_addr == `OFS_COMMAND;
	wire wr_sts = dp_write && dp_addr == `OFS_STATUS;
	wire cmd_zero = wr_cmd & hwdata[`CMD_ZERO];
	wire cmd_clear = wr_cmd & hwdata[`CMD_CLEAR_ZERO];
	wire cmd_commit = wr_cmd & hwdata[`CMD_COMMIT];
	reg auto_active;

	always @(posedge mclk) begin
		if (srst) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_pend) begin
			if (dp_addr == `OFS_CONTROL) begin
				hrdata <= control;
			end else if (dp_addr == `OFS_STATUS) begin
				hrdata <= {18'h00000, pin_on, 3'h0, hold_on,
					auto_active, zero_err, limit_err, stable};
			end else if (dp_addr == `OFS_MOTION_TIME) begin
				hrdata <= {16'h0000, motion_time};
			end else if (dp_addr == `OFS_MOTION_WIDTH) begin
				hrdata <= {8'h00, motion_width};
			end else if (dp_addr == `OFS_TRACK_TIME) begin
				hrdata <= {16'h0000, track_time};
			end else if (dp_addr == `OFS_TRACK_WIDTH) begin
				hrdata <= {8'h00, track_width};
			end else if (dp_addr == `OFS_ZERO_OFFSET) begin
				hrdata <= {8'h00, zero_offset};
			end else if (dp_addr == `OFS_ZERO_LIMIT) begin
				hrdata <= {8'h00, zero_limit};
			end else if (dp_addr == `OFS_NEAR_ZERO) begin
				hrdata <= {8'h00, near_zero};
			end else if (dp_addr == `OFS_LIMIT_UO) begin
				hrdata <= {8'h00, lim_uo};
			end else if (dp_addr == `OFS_LIMIT_UI) begin
				hrdata <= {8'h00, lim_ui};
			end else if (dp_addr == `OFS_LIMIT_LI) begin
				hrdata <= {8'h00, lim_li};
			end else if (dp_addr == `OFS_LIMIT_LO) begin
				hrdata <= {8'h00, lim_lo};
			end else if (dp_addr == `OFS_INDICATOR) begin
				hrdata <= {8'h00, indicator_value};
			end else if (dp_addr == `OFS_ZERO_ADJUST) begin
				hrdata <= {8'h00, zero_adjust};
			end else begin
				hrdata <= 32'h0000_0000;
			end
		end
	end

	// Staged limits and setting registers
	wire ord_ok = lt(outer_en ? stage_lo : lim_lo, stage_li) &&
		lt(stage_li, stage_ui) &&
		lt(stage_ui, outer_en ? stage_uo : lim_uo);

	always @(posedge mclk) begin
		if (srst) begin
			control <= `CONTROL_RESET;
			motion_time <= 16'h0000;
			motion_width <= 24'h000000;
			track_time <= 16'h0000;
			track_width <= 24'h000000;
			zero_offset <= 24'h000000;
			zero_limit <= 24'h000000;
			near_zero <= 24'h000000;
			stage_uo <= `LIMIT_UO_RESET;
			stage_ui <= `LIMIT_UI_RESET;
			stage_li <= `LIMIT_LI_RESET;
			stage_lo <= `LIMIT_LO_RESET;
			lim_uo <= `LIMIT_UO_RESET;
			lim_ui <= `LIMIT_UI_RESET;
			lim_li <= `LIMIT_LI_RESET;
			lim_lo <= `LIMIT_LO_RESET;
			limit_err <= 1'b0;
		end else begin
			if (wr_ctl) begin
				control <= {11'h000, hwdata[20:0]};
			end
			if (dp_write) begin
				if (dp_addr == `OFS_MOTION_TIME) begin
					motion_time <= hwdata[15:0];
				end else if (dp_addr == `OFS_MOTION_WIDTH) begin
					motion_width <= hwdata[23:0];
				end else if (dp_addr == `OFS_TRACK_TIME) begin
					track_time <= hwdata[15:0];
				end else if (dp_addr == `OFS_TRACK_WIDTH) begin
					track_width <= hwdata[23:0];
				end else if (dp_addr == `OFS_ZERO_OFFSET) begin
					zero_offset <= hwdata[23:0];
				end else if (dp_addr == `OFS_ZERO_LIMIT) begin
					zero_limit <= hwdata[23:0];
				end else if (dp_addr == `OFS_NEAR_ZERO) begin
					near_zero <= hwdata[23:0];
				end else if (dp_addr == `OFS_LIMIT_UO && outer_en) begin
					stage_uo <= hwdata[23:0];
				end else if (dp_addr == `OFS_LIMIT_UI) begin
					stage_ui <= hwdata[23:0];
				end else if (dp_addr == `OFS_LIMIT_LI) begin
					stage_li <= hwdata[23:0];
				end else if (dp_addr == `OFS_LIMIT_LO && outer_en) begin
					stage_lo <= hwdata[23:0];
				end
			end
			if (cmd_commit && ord_ok) begin
				lim_ui <= stage_ui;
				lim_li <= stage_li;
				if (outer_en) begin
					lim_uo <= stage_uo;
					lim_lo <= stage_lo;
				end
			end
			// New error wins over a clear in the same cycle
			if (cmd_commit && !ord_ok) begin
				limit_err <= 1'b1;
			end else if (wr_sts && hwdata[`ST_LIMIT_ERR]) begin
				limit_err <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Long moving average
	// ----------------------------------------
	// Buffer fills always, so switching in needs no warm-up
	reg [23:0] avg_buf [0:`AVG_LONG_LEN-1];
	reg [9:0] avg_idx;
	reg avg_full;
	reg [33:0] avg_sum;
	wire [23:0] avg_old = avg_full ? avg_buf[avg_idx] : 24'h000000;
	wire [23:0] avg_out = avg_sum[33:10];

	always @(posedge mclk) begin
		if (sample_valid) begin
			avg_buf[avg_idx] <= sample_value;
		end
	end

	always @(posedge mclk) begin
		if (srst) begin
			avg_idx <= 10'h000;
			avg_full <= 1'b0;
			avg_sum <= 34'h000000000;
			auto_active <= 1'b0;
		end else begin
			if (sample_valid) begin
				avg_idx <= avg_idx + 10'h001;
				avg_full <= avg_full | (avg_idx == 10'h3FF);
				avg_sum <= avg_sum + {{10{sample_value[23]}}, sample_value}
					- {{10{avg_old[23]}}, avg_old};
			end
			auto_active <= auto_en & stable & avg_full &
				~graph_active & ~hold_on;
		end
	end

	// ----------------------------------------
	// Indicator value
	// ----------------------------------------
	wire [23:0] filtered = auto_active ? avg_out : sample_value;
	wire [23:0] ind_next = filtered - zero_offset - zero_adjust;
	wire [23:0] strain_next = {sample_value[22:0], 1'b0};
	reg [23:0] raw_last;

	always @(posedge mclk) begin
		if (srst) begin
			indicator_value <= 24'h000000;
			analog_value <= 24'h000000;
			raw_last <= 24'h000000;
		end else if (sample_valid) begin
			raw_last <= sample_value;
			if (!check_mode) begin
				indicator_value <= strain_mode ? strain_next : ind_next;
				analog_value <= data_raw ? sample_value :
					(strain_mode ? strain_next : ind_next);
			end
		end
	end

	// ----------------------------------------
	// Motion detect
	// ----------------------------------------
	reg [20:0] tick_cnt;
	reg tick;
	reg [23:0] motion_ref;
	reg moved;
	reg [15:0] still_ticks;
	wire tick_wrap = tick_cnt == MOTION_REF_CYCLES[20:0] - 21'h000001;
	wire big_move = mag(diff(indicator_value, motion_ref)) >= {1'b0, motion_width};

	always @(posedge mclk) begin
		if (srst) begin
			tick_cnt <= 21'h000000;
			tick <= 1'b0;
			motion_ref <= 24'h000000;
			moved <= 1'b1;
			still_ticks <= 16'h0000;
			stable <= 1'b0;
		end else begin
			tick <= tick_wrap;
			tick_cnt <= tick_wrap ? 21'h000000 : tick_cnt + 21'h000001;
			if (tick) begin
				motion_ref <= indicator_value;
				moved <= 1'b0;
				// A jump landing on the tick still counts as motion
				if (moved || big_move) begin
					still_ticks <= 16'h0000;
				end else if (still_ticks != 16'hFFFF) begin
					still_ticks <= still_ticks + 16'h0001;
				end
			end else if (big_move) begin
				moved <= 1'b1;
			end
			stable <= !moved && still_ticks >= motion_time;
		end
	end

	// ----------------------------------------
	// Digital zero and tracking
	// ----------------------------------------
	reg [15:0] track_cnt;
	wire track_off = track_time == 16'h0000 &&
		track_width == 24'h000000;
	wire zero_req = cmd_zero | (zero_pin_on & ~zero_pin_d);
	wire zero_go = zero_req & dz_en & cal_lock;
	wire track_due = tick && track_cnt + 16'h0001 >= track_time;

	always @(posedge mclk) begin
		if (srst) begin
			zero_pin_d <= 1'b0;
			track_cnt <= 16'h0000;
			zero_adjust <= 24'h000000;
			zero_err <= 1'b0;
		end else begin
			zero_pin_d <= zero_pin_on;
			if (tick) begin
				track_cnt <= track_due ? 16'h0000 : track_cnt + 16'h0001;
			end
			if (cmd_clear) begin
				zero_adjust <= 24'h000000;
			end else if (zero_go) begin
				if (mag({raw_last[23], raw_last}) <= {1'b0, zero_limit}) begin
					zero_adjust <= zero_adjust + indicator_value;
				end
			end else if (track_due && !track_off && dz_en && cal_lock &&
				mag({indicator_value[23], indicator_value}) <=
				{1'b0, track_width}) begin
				zero_adjust <= zero_adjust + indicator_value;
			end
			if (zero_go &&
				mag({raw_last[23], raw_last}) > {1'b0, zero_limit}) begin
				zero_err <= 1'b1;
			end else if (wr_sts && hwdata[`ST_ZERO_ERR]) begin
				zero_err <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Limit judgment
	// ----------------------------------------
	// Index 0..3 = lower outer, lower inner, upper inner, upper outer
	reg [3:0] side_hi;
	reg [3:0] over;
	reg [3:0] under;
	reg [3:0] hit;
	reg gate;
	reg near;

	always @* begin
		near = mag({indicator_value[23], indicator_value}) <= {1'b0, near_zero};
		side_hi = 4'h0;
		if (pattern == 3'h0) begin
			side_hi = 4'hF;
		end else if (pattern == 3'h1) begin
			side_hi = 4'hE;
		end else if (pattern == 3'h2) begin
			side_hi = 4'hC;
		end else if (pattern == 3'h3) begin
			side_hi = 4'h8;
		end
		over = {lt(lim_uo, indicator_value), lt(lim_ui, indicator_value),
			lt(lim_li, indicator_value), lt(lim_lo, indicator_value)};
		under = {lt(indicator_value, lim_uo), lt(indicator_value, lim_ui),
			lt(indicator_value, lim_li), lt(indicator_value, lim_lo)};
		hit = (side_hi & over) | (~side_hi & under);
		if (area_mode) begin
			// Inner areas end at the next limit on the same side
			hit[2] = hit[2] & ~(side_hi[3] & outer_en & hit[3]);
			hit[1] = hit[1] & ~(~side_hi[0] & outer_en & hit[0]);
			hit[1] = hit[1] & ~(side_hi[1] & side_hi[2] & hit[2]);
			hit[2] = hit[2] & ~(~side_hi[2] & ~side_hi[1] & under[1]);
		end
		if (!outer_en) begin
			hit[3] = 1'b0;
			hit[0] = 1'b0;
		end
		case (comp_mode)
			3'h0: gate = 1'b1;
			3'h1: gate = stable;
			3'h2: gate = ~near;
			3'h3: gate = stable & ~near;
			3'h4: gate = hold_on;
			default: gate = 1'b0;
		endcase
		gate = gate & (judge_on | ~judge_sig);
	end

	always @(posedge mclk) begin
		if (srst) begin
			upper_outer_judgment <= 1'b0;
			upper_inner_judgment <= 1'b0;
			pass_judgment <= 1'b0;
			lower_inner_judgment <= 1'b0;
			lower_outer_judgment <= 1'b0;
		end else if (check_mode) begin
			upper_outer_judgment <= check_sel == 3'h4;
			upper_inner_judgment <= check_sel == 3'h3;
			pass_judgment <= check_sel == 3'h2;
			lower_inner_judgment <= check_sel == 3'h1;
			lower_outer_judgment <= check_sel == 3'h0;
		end else begin
			upper_outer_judgment <= gate & hit[3];
			upper_inner_judgment <= gate & hit[2];
			pass_judgment <= gate & (hit == 4'h0);
			lower_inner_judgment <= gate & hit[1];
			lower_outer_judgment <= gate & hit[0];
		end
	end

endmodule

// [dv/indicator_zero_and_limit_compare_props.sv]
// Concurrent checks on the ports of the indicator block.
// Assumes hready is looped back from hreadyout by the bench.
`timescale 1ns/1ps
module indicator_zero_and_limit_compare_props (
	input wire mclk, // clock
	input wire srst, // sync reset
	input wire hsel, // select
	input wire [1:0] htrans, // transfer type
	input wire hwrite, // write
	input wire hready, // bus ready
	input wire hreadyout, // slave ready
	input wire [31:0] hrdata, // read data
	input wire hresp, // response
	input wire sample_valid, // sample strobe
	input wire [23:0] indicator_value, // indicator
	input wire stable, // motion result
	input wire upper_outer_judgment, // uo
	input wire upper_inner_judgment, // ui
	input wire pass_judgment, // pass
	input wire lower_inner_judgment, // li
	input wire lower_outer_judgment // lo
);
default clocking @(posedge mclk); endclocking
default disable iff (srst);
wire rd_take = hsel & htrans[1] & hready & ~hwrite;
wire wr_take = hsel & htrans[1] & hready & hwrite;
wire [3:0] hits = {upper_outer_judgment, upper_inner_judgment, lower_inner_judgment,
	lower_outer_judgment};
a_resp_always_okay: assert property (hresp == 1'b0)
	else $error("response not OKAY");
a_read_one_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
	else $error("read wait state wrong");
a_write_no_wait: assert property (wr_take |=> hreadyout)
	else $error("write stalled");
a_wait_has_cause: assert property (!hreadyout |-> $past(rd_take))
	else $error("wait without read");
a_rdata_held: assert property (hreadyout |=> $stable(hrdata))
	else $error("read data moved");
a_reset_clears: assert property (disable iff (1'b0) srst |=> (indicator_value == 24'h0
	&& !stable && hits == 4'h0 && !pass_judgment)) else $error("outputs not cleared");
a_pass_alone: assert property (pass_judgment |-> hits == 4'h0)
	else $error("pass with a limit hit");
a_indicator_paced: assert property (!sample_valid |=> $stable(indicator_value))
	else $error("indicator moved without sample");
endmodule
bind indicator_zero_and_limit_compare indicator_zero_and_limit_compare_props u_props (
	.mclk(mclk), .srst(srst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
	.sample_valid(sample_valid), .indicator_value(indicator_value), .stable(stable),
	.upper_outer_judgment(upper_outer_judgment), .upper_inner_judgment(upper_inner_judgment),
	.pass_judgment(pass_judgment), .lower_inner_judgment(lower_inner_judgment),
	.lower_outer_judgment(lower_outer_judgment));

// [dv/sensor_front_model.sv]
// Sensor front end and control terminals in front of the block.
// Assumes one sample strobe every eight clocks.
`timescale 1ns/1ps
module sensor_front_model (
	input wire mclk, // clock
	input wire srst, // sync reset
	input wire [23:0] level, // sensor level to send
	input wire [5:0] pin_on, // terminals to switch on
	output reg sample_valid, // sample strobe
	output reg [23:0] sample_value, // sample bus
	output wire [5:0] pins_n // terminal levels
);
reg [2:0] div;
// On means a low level at the terminal
assign pins_n = ~pin_on;
// Bus shows garbage between strobes so stale values are not relied on
always @(posedge mclk) begin
	if (srst) begin
		div <= 3'h0;
		sample_valid <= 1'b0;
		sample_value <= 24'h0;
	end else begin
		div <= div + 3'h1;
		sample_valid <= (div == 3'h7);
		sample_value <= (div == 3'h7) ? level : ~level;
	end
end
endmodule

// [dv/tb_top.sv]
// Self-checking bench: AHB-Lite tasks, sample model, port checks.
// Assumes the sample model paces one sample per eight clocks.
`timescale 1ns/1ps
`include "indicator_zero_and_limit_compare_regs.vh"
module tb_top;
reg mclk;
reg srst = 1'b1;
reg hsel = 1'b0;
reg hwrite = 1'b0;
reg [1:0] htrans = 2'h0;
reg [31:0] haddr = 32'h0;
reg [31:0] hwdata = 32'h0;
reg [23:0] level = 24'h0;
reg [5:0] pin_on = 6'h0;
reg [31:0] rd;
wire hreadyout, hresp, sample_valid, stable, uo, ui, ps, li, lo;
wire [31:0] hrdata;
wire [23:0] sample_value, ind, ana;
wire [5:0] pins_n;
wire [4:0] jd = {uo, ui, ps, li, lo};
int fail_count = 0;
int compares = 0;
int i;
initial begin
	mclk = 1'b0;
	forever #25 mclk = ~mclk;
end
sensor_front_model partner (.mclk(mclk), .srst(srst), .level(level), .pin_on(pin_on),
	.sample_valid(sample_valid), .sample_value(sample_value), .pins_n(pins_n));
indicator_zero_and_limit_compare #(.MOTION_REF_CYCLES(20)) dut (.mclk(mclk), .srst(srst),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
	.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
	.hresp(hresp), .sample_valid(sample_valid), .sample_value(sample_value),
	.graph_active(1'b0), .zero_req_n(pins_n[0]), .hold_n(pins_n[1]), .judge_n(pins_n[2]),
	.clear_n(pins_n[3]), .select_input_a_n(pins_n[4]), .select_input_b_n(pins_n[5]),
	.indicator_value(ind), .analog_value(ana), .stable(stable),
	.upper_outer_judgment(uo), .upper_inner_judgment(ui), .pass_judgment(ps),
	.lower_inner_judgment(li), .lower_outer_judgment(lo));
// ----------------------------------------
// Tasks
// ----------------------------------------
task check(input string name, input [31:0] seen, input [31:0] exp);
	compares++;
	if (seen !== exp) begin
		fail_count++;
		$display("[FAIL] %s expected %h seen %h", name, exp, seen);
	end
endtask
// Entered just after a rising edge; holds each phase until hready
task bus(input w, input [7:0] a, input [31:0] d);
	hsel <= 1'b1;
	htrans <= 2'h2;
	hwrite <= w;
	haddr <= {24'h0, a};
	@(posedge mclk);
	while (hreadyout !== 1'b1) @(posedge mclk);
	hsel <= 1'b0;
	htrans <= 2'h0;
	hwdata <= d;
	@(posedge mclk);
	while (hreadyout !== 1'b1) @(posedge mclk);
	rd = hrdata;
endtask
task wr(input [7:0] a, input [31:0] d);
	bus(1'b1, a, d);
endtask
task rdc(input string name, input [7:0] a, input [31:0] exp);
	bus(1'b0, a, 32'h0);
	check(name, rd, exp);
endtask
// Several samples pass so indicator and judgments settle
task smp(input [23:0] v);
	level <= v;
	repeat (30) @(posedge mclk);
endtask
task report_and_stop;
	$display("compares %0d fail_count %0d", compares, fail_count);
	if (fail_count == 0 && compares > 0)
		$display("No errors found");
	else
		$display("Errors were found");
	$finish;
endtask
// ----------------------------------------
// Tests
// ----------------------------------------
initial begin
	repeat (20000) @(posedge mclk);
	fail_count++;
	report_and_stop;
end
initial begin
	repeat (8) @(posedge mclk);
	srst <= 1'b0;
	rdc("control", `OFS_CONTROL, 32'h2008);
	rdc("limit_uo", `OFS_LIMIT_UO, 32'h2000);
	rdc("limit_lo", `OFS_LIMIT_LO, 32'hFFE000);
	rdc("unmapped", 8'h40, 32'h0);
	rdc("zero_adjust", `OFS_ZERO_ADJUST, 32'h0);
	smp(24'h1800); check("jd", jd, 5'h08);
	smp(24'h3000); check("jd", jd, 5'h18);
	smp(24'hFFE800); check("jd", jd, 5'h02);
	smp(24'hFFD000); check("jd", jd, 5'h03);
	smp(24'h0); check("jd", jd, 5'h04);
	wr(`OFS_CONTROL, 32'h2018);
	smp(24'h3000); check("jd", jd, 5'h10);
	smp(24'hFFD000); check("jd", jd, 5'h01);
	wr(`OFS_NEAR_ZERO, 32'h2000);
	for (i = 2; i < 8; i++) begin
		wr(`OFS_CONTROL, 32'h2008 | (i << 16));
		smp(24'h1800); check("jd", jd, 5'h00);
	end
	pin_on <= 6'h02;
	wr(`OFS_CONTROL, 32'h42008);
	smp(24'h1800); check("jd", jd, 5'h08);
	bus(1'b0, `OFS_STATUS, 32'h0); check("pins", rd & 32'h3F10, 32'h0210);
	pin_on <= 6'h00;
	wr(`OFS_CONTROL, 32'h2000);
	smp(24'h3000); check("jd", jd, 5'h08);
	wr(`OFS_LIMIT_UO, 32'h4000);
	wr(`OFS_COMMAND, 32'h4);
	rdc("limit_uo", `OFS_LIMIT_UO, 32'h2000);
	wr(`OFS_CONTROL, 32'h2008);
	wr(`OFS_LIMIT_LI, 32'h2000);
	wr(`OFS_COMMAND, 32'h4);
	rdc("limit_li", `OFS_LIMIT_LI, 32'hFFF000);
	bus(1'b0, `OFS_STATUS, 32'h0); check("limit_err", rd[1], 32'h1);
	wr(`OFS_STATUS, 32'h2);
	wr(`OFS_LIMIT_LI, 32'hFFF800);
	wr(`OFS_COMMAND, 32'h4);
	rdc("limit_li", `OFS_LIMIT_LI, 32'hFFF800);
	rdc("limit_uo", `OFS_LIMIT_UO, 32'h2000);
	wr(`OFS_ZERO_OFFSET, 32'h100);
	smp(24'h500); check("ind", ind, 32'h400);
	wr(`OFS_CONTROL, 32'h2028);
	smp(24'h500); check("ana", ana, 32'h500);
	wr(`OFS_CONTROL, 32'h2008);
	smp(24'h500); check("ana", ana, 32'h400);
	wr(`OFS_CONTROL, 32'h2048);
	smp(24'h500); check("ind", ind, 32'hA00);
	wr(`OFS_CONTROL, 32'h2008);
	wr(`OFS_COMMAND, 32'h1);
	smp(24'h500); check("ind", ind, 32'h400);
	wr(`OFS_CONTROL, 32'h200A);
	wr(`OFS_COMMAND, 32'h1);
	smp(24'h500); check("ind", ind, 32'h400);
	wr(`OFS_CONTROL, 32'h200E);
	wr(`OFS_ZERO_LIMIT, 32'h10);
	wr(`OFS_COMMAND, 32'h1);
	smp(24'h500); check("ind", ind, 32'h400);
	bus(1'b0, `OFS_STATUS, 32'h0); check("zero_err", rd[2], 32'h1);
	wr(`OFS_ZERO_LIMIT, 32'h1000);
	wr(`OFS_COMMAND, 32'h1);
	smp(24'h500); check("ind", ind, 32'h0);
	wr(`OFS_COMMAND, 32'h2);
	smp(24'h500); check("ind", ind, 32'h400);
	pin_on <= 6'h01;
	smp(24'h500); check("ind", ind, 32'h0);
	pin_on <= 6'h00;
	for (i = 0; i < 5; i++) begin
		wr(`OFS_CONTROL, 32'h208E | (i << 8));
		smp(24'h900); check("jd", jd, 32'h1 << i);
		check("ind", ind, 32'h0);
	end
	wr(`OFS_CONTROL, 32'h200E);
	wr(`OFS_TRACK_WIDTH, 32'h100);
	smp(24'h580); smp(24'h580); check("ind", ind, 32'h0);
	wr(`OFS_CONTROL, 32'h2008);
	smp(24'h680); smp(24'h680); check("ind", ind, 32'h100);
	wr(`OFS_CONTROL, 32'h12008);
	smp(24'h680); check("jd", jd, 5'h00);
	wr(`OFS_MOTION_WIDTH, 32'h100);
	wr(`OFS_MOTION_TIME, 32'h2);
	repeat (4) smp(24'h680);
	check("jd", jd, 5'h04);
	check("stable", stable, 32'h1);
	smp(24'h880); check("jd", jd, 5'h00);
	check("stable", stable, 32'h0);
	wr(`OFS_CONTROL, 32'h12009);
	repeat (300) smp(24'h880);
	bus(1'b0, `OFS_STATUS, 32'h0); check("auto", rd[3], 32'h1);
	check("ind", ind, 32'h300);
	pin_on <= 6'h02;
	smp(24'h880);
	bus(1'b0, `OFS_STATUS, 32'h0); check("auto", rd[3], 32'h0);
	pin_on <= 6'h00;
	report_and_stop;
end
endmodule

// [include/indicator_zero_and_limit_compare_regs.vh]
// Register map, field positions, reset values and timing counts
// for the indicator zero and limit compare block.
// Assumes a 32-bit AHB-Lite bus with word-aligned registers.
`ifndef INDICATOR_ZERO_AND_LIMIT_COMPARE_REGS_VH
`define INDICATOR_ZERO_AND_LIMIT_COMPARE_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CONTROL 8'h00
`define OFS_COMMAND 8'h04
`define OFS_STATUS 8'h08
`define OFS_MOTION_TIME 8'h0C
`define OFS_MOTION_WIDTH 8'h10
`define OFS_TRACK_TIME 8'h14
`define OFS_TRACK_WIDTH 8'h18
`define OFS_ZERO_OFFSET 8'h1C
`define OFS_ZERO_LIMIT 8'h20
`define OFS_NEAR_ZERO 8'h24
`define OFS_LIMIT_UO 8'h28
`define OFS_LIMIT_UI 8'h2C
`define OFS_LIMIT_LI 8'h30
`define OFS_LIMIT_LO 8'h34
`define OFS_INDICATOR 8'h38
`define OFS_ZERO_ADJUST 8'h3C

// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTL_AUTO_FILTER 0
`define CTL_DZ_ENABLE 1
`define CTL_CAL_LOCK 2
`define CTL_OUTER_EN 3
`define CTL_AREA_MODE 4
`define CTL_DATA_RAW 5
`define CTL_STRAIN 6
`define CTL_CHECK 7
`define CTL_CHECK_SEL_LO 8
`define CTL_PATTERN_LO 12
`define CTL_COMP_MODE_LO 16
`define CTL_JUDGE_SIG 20
`define CONTROL_RESET 32'h0000_2008

// Command bits (write pulses)
`define CMD_ZERO 0
`define CMD_CLEAR_ZERO 1
`define CMD_COMMIT 2

// Status bits
`define ST_STABLE 0
`define ST_LIMIT_ERR 1
`define ST_ZERO_ERR 2
`define ST_AUTO_ACTIVE 3
`define ST_HOLD 4
`define ST_PINS_LO 8

// ----------------------------------------
// Values and timing
// ----------------------------------------
`define AVG_LONG_LOG2 10
`define AVG_LONG_LEN 1024
`define MOTION_REF_MS 100
`define MCLK_KHZ 20000
`define MOTION_REF_CYCLES (`MOTION_REF_MS * `MCLK_KHZ)
`define LIMIT_UO_RESET 24'h002000
`define LIMIT_UI_RESET 24'h001000
`define LIMIT_LI_RESET 24'hFFF000
`define LIMIT_LO_RESET 24'hFFE000

`endif
